// ===== hdl/pin_clock_config_registers.sv
// Pin role, delay scale, pull-down, thermal and clock sync configuration bank
`timescale 1ns/1ps
module pin_clock_config_registers #(
  parameter int FINE_STEP_CYCLES = pin_clock_pkg::FINE_CYC
) (
  // Clock, reset, clock enable
  input  wire logic                               clk_i,
  input  wire logic                               reset_i,
  input  wire logic                               ce_i,
  // Register port
  input  wire logic [pin_clock_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic [pin_clock_pkg::DATA_W-1:0]   wdata_i,
  input  wire logic                               wr_i,
  input  wire logic                               rd_i,
  output logic      [pin_clock_pkg::DATA_W-1:0]   rdata_o,
  // One-time memory contents
  input  wire logic [pin_clock_pkg::DATA_W-1:0]   otp_pin_i,
  input  wire logic [pin_clock_pkg::DATA_W-1:0]   otp_cfg_i,
  input  wire logic [pin_clock_pkg::DATA_W-1:0]   otp_clk_i,
  // Device inputs
  input  wire logic                               enable_pin_one_i,
  input  wire logic                               enable_pin_two_i,
  input  wire logic                               enable_pin_three_i,
  input  wire logic                               sync_clock_detected_i,
  input  wire logic                               power_good_status_i,
  input  wire logic                               general_output_one_level_i,
  input  wire logic [pin_clock_pkg::CODE_W-1:0]   startup_code_i,
  input  wire logic [pin_clock_pkg::CODE_W-1:0]   shutdown_code_i,
  // Shared pins
  output logic                                    general_output_two_o,
  output logic                                    general_output_two_oe_n_o,
  output logic                                    sync_clock_input_active_o,
  output logic                                    power_good_pin_o,
  output logic                                    power_good_pin_is_gpo_o,
  // Analog and converter controls
  output logic                                    startup_scale_o,
  output logic                                    shutdown_scale_o,
  output logic                                    sync_input_pulldown_o,
  output logic                                    enable_three_pulldown_o,
  output logic                                    enable_two_pulldown_o,
  output logic                                    enable_one_pulldown_o,
  output logic                                    thermal_warning_threshold_o,
  output logic                                    spread_modulation_on_o,
  // Clock sync controls
  output logic                                    pll_enable_o,
  output logic                                    use_external_clock_o,
  output logic                                    clock_change_event_o,
  output logic      [pin_clock_pkg::FREQ_W-1:0]   sync_clock_frequency_code_o,
  output logic                                    frequency_code_reserved_o
);
  import pin_clock_pkg::*;

  typedef struct packed {
    phase_e            phase;
    logic [DATA_W-1:0] pin_cfg;
    logic [DATA_W-1:0] dly_cfg;
    logic [DATA_W-1:0] clk_cfg;
    logic [DATA_W-1:0] rdata;
    logic              det_q;
    logic              req;
    logic              general_output_two;
    logic              oe_n;
    logic              clk_act;
    logic              pg_pin;
    logic              pg_gpo;
    logic              su;
    logic              sd;
    logic              pd_clk;
    logic              pd3;
    logic              pd2;
    logic              pd1;
    logic              therm;
    logic              spread;
    logic              pll_en;
    logic              use_ext;
    logic              evt;
    logic [FREQ_W-1:0] freq;
    logic              rsv;
  } bank_s;

  bank_s ff;
  bank_s nxt;
  logic  tmr_level;
  logic  tmr_busy;

  // Pick the enable pin that gates output two
  function automatic logic gate_pin(input logic [1:0] code, input logic e1,
                                    input logic e2, input logic e3);
    case (code)
      GATE_NONE: gate_pin = 1'b1;
      GATE_EN1:  gate_pin = e1;
      GATE_EN2:  gate_pin = e2;
      GATE_EN3:  gate_pin = e3;
      default:   gate_pin = 1'b1;
    endcase
  endfunction

  // Codes from the reserved range are flagged, never acted on here
  function automatic logic code_reserved(input logic [FREQ_W-1:0] code);
    code_reserved = (code >= FREQ_RSV);
  endfunction

  // Startup and shutdown delays of output two
  output_delay_timer #(
    .FINE_STEP_CYCLES (FINE_STEP_CYCLES)
  ) u_delay (
    .clk_i          (clk_i),
    .reset_i        (reset_i),
    .ce_i           (ce_i),
    .target_i       (ff.req),
    .start_code_i   (startup_code_i),
    .stop_code_i    (shutdown_code_i),
    .start_coarse_i (ff.dly_cfg[B_SU]),
    .stop_coarse_i  (ff.dly_cfg[B_SD]),
    .level_o        (tmr_level),
    .busy_o         (tmr_busy)
  );

  // Register updates, read port and derived pin controls
  always_comb begin
    nxt       = ff;
    nxt.rdata = '0;
    case (ff.phase)
      ST_LOAD: begin
        // Reserved bits are masked so they still come up as zero
        nxt.pin_cfg = otp_pin_i & MASK_PIN;
        nxt.dly_cfg = otp_cfg_i & MASK_CFG;
        nxt.clk_cfg = otp_clk_i & MASK_CLK;
        nxt.phase   = ST_RUN;
      end
      ST_RUN: begin
        if (wr_i) begin
          case (addr_i)
            OFS_PIN: nxt.pin_cfg = wdata_i;
            OFS_CFG: nxt.dly_cfg = wdata_i;
            OFS_CLK: nxt.clk_cfg = wdata_i;
            default: nxt.pin_cfg = ff.pin_cfg;
          endcase
        end
      end
      default: begin
        nxt.phase = ST_LOAD;
      end
    endcase

    // Read data stands for exactly the cycle after the strobe
    if (rd_i) begin
      case (addr_i)
        OFS_PIN:    nxt.rdata = ff.pin_cfg;
        OFS_CFG:    nxt.rdata = ff.dly_cfg;
        OFS_CLK:    nxt.rdata = ff.clk_cfg;
        OFS_STATUS: nxt.rdata = {1'b0, ff.phase == ST_LOAD, ff.rsv, tmr_busy,
                                 ff.req, tmr_level, ff.use_ext, ff.det_q};
        default:    nxt.rdata = '0;
      endcase
    end

    // Output-two request: level bit AND the selected enable pin
    nxt.req = nxt.pin_cfg[B_LVL]
            & gate_pin(nxt.pin_cfg[B_GTHI:B_GTLO], enable_pin_one_i,
                       enable_pin_two_i, enable_pin_three_i);

    // Shared clock pin: released while it serves as sync clock input
    nxt.clk_act = !nxt.pin_cfg[B_ROLE2];
    if (!nxt.pin_cfg[B_ROLE2]) begin
      nxt.general_output_two = 1'b0;
      nxt.oe_n = 1'b1;
    end else if (nxt.pin_cfg[B_OD]) begin
      nxt.general_output_two = 1'b0;
      nxt.oe_n = tmr_level;
    end else begin
      nxt.general_output_two = tmr_level;
      nxt.oe_n = 1'b0;
    end

    // Power-good pin role
    nxt.pg_gpo = nxt.pin_cfg[B_ROLE1];
    nxt.pg_pin = nxt.pin_cfg[B_ROLE1] ? general_output_one_level_i
                                      : power_good_status_i;

    // Delay scales and analog controls follow the register directly
    nxt.su     = nxt.dly_cfg[B_SU];
    nxt.sd     = nxt.dly_cfg[B_SD];
    nxt.pd_clk = nxt.dly_cfg[B_PDCLK];
    nxt.pd3    = nxt.dly_cfg[B_PD3];
    nxt.pd2    = nxt.dly_cfg[B_PD2];
    nxt.pd1    = nxt.dly_cfg[B_PD1];
    nxt.therm  = nxt.dly_cfg[B_THERM];
    nxt.spread = nxt.dly_cfg[B_SPRD];

    // Clock sync: external clock only counts while the pin is an input
    nxt.pll_en  = nxt.clk_cfg[B_PLL];
    nxt.use_ext = nxt.clk_cfg[B_PLL] & sync_clock_detected_i
                & !nxt.pin_cfg[B_ROLE2];
    nxt.det_q   = sync_clock_detected_i;
    nxt.evt     = nxt.clk_cfg[B_PLL]
                & (sync_clock_detected_i != ff.det_q);
    nxt.freq    = nxt.clk_cfg[B_FQHI:0];
    nxt.rsv     = code_reserved(nxt.clk_cfg[B_FQHI:0]);
  end

  // State register; the fractional bit is stored but steers nothing
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ff         <= '0;
      ff.phase   <= ST_LOAD;
      ff.pin_cfg <= RST_PIN;
      ff.dly_cfg <= RST_CFG;
      ff.clk_cfg <= RST_CLK;
      ff.oe_n    <= 1'b1;
      ff.clk_act <= 1'b1;
      ff.pd_clk  <= 1'b1;
      ff.pd3     <= 1'b1;
      ff.pd2     <= 1'b1;
      ff.pd1     <= 1'b1;
      ff.freq    <= RST_CLK[B_FQHI:0];
    end else if (ce_i) begin
      ff <= nxt;
    end
  end

  // Outputs straight from the state register
  assign rdata_o                     = ff.rdata;
  assign general_output_two_o        = ff.general_output_two;
  assign general_output_two_oe_n_o   = ff.oe_n;
  assign sync_clock_input_active_o   = ff.clk_act;
  assign power_good_pin_o            = ff.pg_pin;
  assign power_good_pin_is_gpo_o     = ff.pg_gpo;
  assign startup_scale_o             = ff.su;
  assign shutdown_scale_o            = ff.sd;
  assign sync_input_pulldown_o       = ff.pd_clk;
  assign enable_three_pulldown_o     = ff.pd3;
  assign enable_two_pulldown_o       = ff.pd2;
  assign enable_one_pulldown_o       = ff.pd1;
  assign thermal_warning_threshold_o = ff.therm;
  assign spread_modulation_on_o      = ff.spread;
  assign pll_enable_o                = ff.pll_en;
  assign use_external_clock_o        = ff.use_ext;
  assign clock_change_event_o        = ff.evt;
  assign sync_clock_frequency_code_o = ff.freq;
  assign frequency_code_reserved_o   = ff.rsv;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i || !ce_i);

  // Disable looks at the present enable, so a frozen edge is excluded by its sampled value
  sequence load_cycle;
    ce_i && ff.phase == ST_LOAD;
  endsequence

  sequence otp_applied;
    ff.pin_cfg == ($past(otp_pin_i) & MASK_PIN)
    && ff.clk_cfg == ($past(otp_clk_i) & MASK_CLK)
    && ff.dly_cfg == $past(otp_cfg_i);
  endsequence

  sequence cfg_write;
    ce_i && ff.phase == ST_RUN && wr_i && addr_i == OFS_CFG;
  endsequence

  otp_load_a: assert property (load_cycle |=> otp_applied)
    else $error("one-time memory values not loaded");

  cfg_effect_a: assert property (cfg_write |=>
    {sync_input_pulldown_o, enable_three_pulldown_o, enable_two_pulldown_o,
     enable_one_pulldown_o, thermal_warning_threshold_o,
     spread_modulation_on_o} == $past(wdata_i[5:0]))
    else $error("config write not reflected on outputs");

  scale_out_a: assert property (cfg_write |=>
    startup_scale_o == $past(wdata_i[B_SU])
    && shutdown_scale_o == $past(wdata_i[B_SD]))
    else $error("delay scale outputs wrong after write");

  clock_role_a: assert property (sync_clock_input_active_o
    |-> general_output_two_oe_n_o && !general_output_two_o)
    else $error("shared clock pin driven while an input");

  open_drain_a: assert property (!sync_clock_input_active_o
    && ff.pin_cfg[B_OD] |-> !general_output_two_o)
    else $error("open-drain output drives high");

  pg_role_a: assert property (##1 power_good_pin_o ==
    (ff.pin_cfg[B_ROLE1] ? $past(general_output_one_level_i)
                         : $past(power_good_status_i)))
    else $error("power-good pin shows wrong source");

  gate_req_a: assert property (ce_i && ff.phase == ST_RUN && !wr_i |=>
    ff.req == (ff.pin_cfg[B_LVL] & gate_pin(ff.pin_cfg[B_GTHI:B_GTLO],
      $past(enable_pin_one_i), $past(enable_pin_two_i),
      $past(enable_pin_three_i))))
    else $error("output-two request not gated correctly");

  pll_off_a: assert property (!pll_enable_o |-> !use_external_clock_o
    && !clock_change_event_o)
    else $error("external clock used while PLL is off");

  ext_use_a: assert property (##1 pll_enable_o && sync_clock_input_active_o
    && $past(sync_clock_detected_i) |-> use_external_clock_o)
    else $error("present external clock not used");

  clk_event_a: assert property (pll_enable_o && sync_clock_detected_i != ff.det_q
    && $stable(ff.clk_cfg) ##0 ff.clk_cfg == nxt.clk_cfg
    |=> clock_change_event_o)
    else $error("clock detect change gave no event");

  freq_rsv_a: assert property (frequency_code_reserved_o ==
    (sync_clock_frequency_code_o >= FREQ_RSV))
    else $error("reserved frequency flag wrong");
endmodule

// ===== shared/pin_clock_pkg.sv
// Constants, register map and types for the pin and clock configuration bank
package pin_clock_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CODE_W = 4;
  localparam int FREQ_W = 5;
  localparam int STEP_W = 5;
  localparam int PRE_W  = 16;
  // Register offsets, status is a read-only view of block state
  localparam logic [ADDR_W-1:0] OFS_PIN    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CFG    = 8'h11;
  localparam logic [ADDR_W-1:0] OFS_CLK    = 8'h12;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
  // Nominal reset values and masks of configurable fields
  localparam logic [DATA_W-1:0] RST_PIN  = 8'h0a;
  localparam logic [DATA_W-1:0] RST_CFG  = 8'h3c;
  localparam logic [DATA_W-1:0] RST_CLK  = 8'h02;
  localparam logic [DATA_W-1:0] MASK_PIN = 8'h3f;
  localparam logic [DATA_W-1:0] MASK_CFG = 8'hff;
  localparam logic [DATA_W-1:0] MASK_CLK = 8'h7f;
  // Field positions, output-two register
  localparam int B_ROLE2 = 5;
  localparam int B_ROLE1 = 4;
  localparam int B_OD    = 3;
  localparam int B_GTHI  = 2;
  localparam int B_GTLO  = 1;
  localparam int B_LVL   = 0;
  // Field positions, delay/pull-down/thermal register
  localparam int B_SU    = 7;
  localparam int B_SD    = 6;
  localparam int B_PDCLK = 5;
  localparam int B_PD3   = 4;
  localparam int B_PD2   = 3;
  localparam int B_PD1   = 2;
  localparam int B_THERM = 1;
  localparam int B_SPRD  = 0;
  // Field positions, clock sync register
  localparam int B_PLL   = 6;
  localparam int B_FRAC  = 5;
  localparam int B_FQHI  = 4;
  // Gating codes and first reserved frequency code
  localparam logic [1:0] GATE_NONE = 2'h0;
  localparam logic [1:0] GATE_EN1  = 2'h1;
  localparam logic [1:0] GATE_EN2  = 2'h2;
  localparam logic [1:0] GATE_EN3  = 2'h3;
  localparam logic [FREQ_W-1:0] FREQ_RSV = 5'h18;
  // Delay step timing
  localparam int CLK_MHZ      = 50;
  localparam int FINE_STEP_US = 500;
  localparam int COARSE_US    = 1000;
  localparam int FINE_CYC     = FINE_STEP_US * CLK_MHZ;
  localparam int COARSE_RATIO = COARSE_US / FINE_STEP_US;

  typedef enum logic {ST_LOAD, ST_RUN} phase_e;

  // Count of fine steps for a delay code and scale
  function automatic logic [STEP_W-1:0] fine_steps(input logic [CODE_W-1:0] code,
                                                   input logic coarse);
    logic [STEP_W-1:0] c;
    c = {1'b0, code};
    fine_steps = coarse ? STEP_W'(c * COARSE_RATIO) : c;
  endfunction
endpackage

// ===== hdl/output_delay_timer.sv
// Startup and shutdown delay of one general output
`timescale 1ns/1ps
module output_delay_timer #(
  parameter int FINE_STEP_CYCLES = pin_clock_pkg::FINE_CYC
) (
  // Clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              reset_i,
  input  wire logic                              ce_i,
  // Control and delay settings
  input  wire logic                              target_i,
  input  wire logic [pin_clock_pkg::CODE_W-1:0]  start_code_i,
  input  wire logic [pin_clock_pkg::CODE_W-1:0]  stop_code_i,
  input  wire logic                              start_coarse_i,
  input  wire logic                              stop_coarse_i,
  // Delayed level
  output logic                                   level_o,
  output logic                                   busy_o
);
  import pin_clock_pkg::*;

  typedef struct packed {
    logic              level;
    logic              busy;
    logic [STEP_W-1:0] steps;
    logic [PRE_W-1:0]  pre;
  } tmr_s;

  tmr_s ff;
  tmr_s nxt;
  logic [STEP_W-1:0] load;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(FINE_STEP_CYCLES - 1);

  // A reversal of the control edge while counting cancels the delay
  always_comb begin
    nxt  = ff;
    load = target_i ? fine_steps(start_code_i, start_coarse_i)
                    : fine_steps(stop_code_i, stop_coarse_i);
    if (target_i == ff.level) begin
      nxt.busy = 1'b0;
    end else if (!ff.busy) begin
      if (load == '0) begin
        nxt.level = target_i;
      end else begin
        nxt.busy  = 1'b1;
        nxt.steps = load;
        nxt.pre   = '0;
      end
    end else if (ff.pre == PRE_LAST) begin
      nxt.pre   = '0;
      nxt.steps = ff.steps - 1'b1;
      if (ff.steps == 5'h01) begin
        nxt.level = target_i;
        nxt.busy  = 1'b0;
      end
    end else begin
      nxt.pre = ff.pre + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ff <= '0;
    end else if (ce_i) begin
      ff <= nxt;
    end
  end

  assign level_o = ff.level;
  assign busy_o  = ff.busy;

  idle_level_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !ff.busy && $past(!ff.busy) && $stable(target_i) && ce_i && $past(ce_i)
    |-> ##1 !ce_i || level_o == $past(target_i))
    else $error("idle timer level differs from control");
endmodule

// ===== verification/test_pin_clock_config_registers.sv
// Self-checking bench for the pin and clock configuration bank
`timescale 1ns/1ps
module test_pin_clock_config_registers;
  import pin_clock_pkg::*;
  // Short prescale keeps delay runs brief
  localparam int FINE = 4;
  logic       clk_i, reset_i, ce_i, wr_i, rd_i;
  logic [7:0] addr_i, wdata_i, rdata_o, otp_pin_i, otp_cfg_i, otp_clk_i;
  logic       en1, en2, en3, det, pg, general_output_one;
  logic [3:0] su_code, sd_code;
  logic       general_output_two, general_output_two_oe_n, clk_act, pg_pin, pg_gpo, su_sc, sd_sc;
  logic       pd_clk, pd3, pd2, pd1, therm, sprd, pll_en, use_ext, evt, frq_rsv;
  logic [4:0] frq;
  int         bad_count, check_count, seed, n, lvl, st;
  int         m[3];

  pin_clock_config_registers #(.FINE_STEP_CYCLES(FINE)) pin_clock_config_registers_inst (
    .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .otp_pin_i(otp_pin_i),
    .otp_cfg_i(otp_cfg_i), .otp_clk_i(otp_clk_i), .enable_pin_one_i(en1),
    .enable_pin_two_i(en2), .enable_pin_three_i(en3), .sync_clock_detected_i(det),
    .power_good_status_i(pg), .general_output_one_level_i(general_output_one),
    .startup_code_i(su_code), .shutdown_code_i(sd_code), .general_output_two_o(general_output_two),
    .general_output_two_oe_n_o(general_output_two_oe_n), .sync_clock_input_active_o(clk_act),
    .power_good_pin_o(pg_pin), .power_good_pin_is_gpo_o(pg_gpo), .startup_scale_o(su_sc),
    .shutdown_scale_o(sd_sc), .sync_input_pulldown_o(pd_clk), .enable_three_pulldown_o(pd3),
    .enable_two_pulldown_o(pd2), .enable_one_pulldown_o(pd1),
    .thermal_warning_threshold_o(therm), .spread_modulation_on_o(sprd),
    .pll_enable_o(pll_en), .use_external_clock_o(use_ext), .clock_change_event_o(evt),
    .sync_clock_frequency_code_o(frq), .frequency_code_reserved_o(frq_rsv)
  );

  // Clock source, 20 ns period
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Single compare point, so every mismatch is counted the same way
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write; the model only tracks mapped registers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    if (a >= 8'h10 && a <= 8'h12) m[a - 8'h10] = d;
  endtask

  // One-cycle read; data is looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    logic [7:0] x;
    x = (a == 8'h18) ? 8'(st) : 8'h00; // Status view is modelled by the caller
    if (a >= 8'h10 && a <= 8'h12) x = 8'(m[a - 8'h10]);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, x);
  endtask

  // Static configuration outputs against the model
  task automatic check_outs;
    logic [7:0] p, c, k;
    p = 8'(m[0]);
    c = 8'(m[1]);
    k = 8'(m[2]);
    #1;
    chk({su_sc, sd_sc, pd_clk, pd3, pd2, pd1, therm, sprd}, c);
    chk({7'h00, clk_act}, {7'h00, !p[5]});
    chk({7'h00, pg_gpo}, {7'h00, p[4]});
    chk({2'h0, pll_en, frq}, {2'h0, k[6], k[4:0]});
    chk({7'h00, frq_rsv}, {7'h00, k[4:0] >= 5'h18});
    chk({7'h00, use_ext}, {7'h00, k[6] & det & !p[5]});
  endtask

  // Shared pin levels once the zero-length delay path has settled
  task automatic check_pin;
    logic [7:0] p;
    logic [3:0] e;
    logic       l;
    p = 8'(m[0]);
    e = {en3, en2, en1, 1'b1};
    l = p[0] & e[p[2:1]];
    repeat (8) @(posedge clk_i);
    #1;
    if (!p[5]) chk({6'h00, general_output_two, general_output_two_oe_n}, 8'h01);
    else if (p[3]) chk({6'h00, general_output_two, general_output_two_oe_n}, {7'h00, l});
    else chk({6'h00, general_output_two, general_output_two_oe_n}, {6'h00, l, 1'b0});
    chk({7'h00, pg_pin}, {7'h00, p[4] ? general_output_one : pg});
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #(20 * 20000);
    bad_count++;
    tally_and_finish;
  end

  // Main sequence
  initial begin
    seed = 96;
    bad_count = 0;
    check_count = 0;
    reset_i = 1'b1;
    ce_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    {en1, en2, en3, det, pg, general_output_one} = 6'h00;
    su_code = 4'h0;
    sd_code = 4'h0;
    otp_pin_i = 8'($random(seed));
    otp_cfg_i = 8'($random(seed));
    otp_clk_i = 8'($random(seed)) & 8'h5f; // Fractional bit kept clear
    m[0] = 8'h0a;
    m[1] = 8'h3c;
    m[2] = 8'h02;
    repeat (4) @(posedge clk_i);
    check_outs;
    reset_i <= 1'b0;
    m[0] = otp_pin_i & 8'h3f;
    m[1] = otp_cfg_i;
    m[2] = otp_clk_i & 8'h7f;
    repeat (2) @(posedge clk_i);
    check_outs;
    for (int i = 0; i < 3; i++) rd(8'h10 + 8'(i));
    wr(8'h20, 8'hff);
    rd(8'h20);
    // Random register traffic with random pin inputs
    for (int i = 0; i < 18; i++) begin
      n = $random(seed);
      {en3, en2, en1, det, pg, general_output_one} <= 6'(n >>> 8);
      case (i % 3)
        0: wr(8'h10, 8'(n));
        1: wr(8'h11, 8'(n));
        default: begin
          wr(8'h12, 8'(m[2]) & 8'hbf); // Sync off before a code change
          wr(8'h12, 8'(n) & 8'hdf);
        end
      endcase
      check_outs;
      check_pin;
      rd(8'h10 + 8'(i % 3));
    end
    // Clock enable low freezes everything, so a write in that window is lost
    n = m[1];
    ce_i <= 1'b0;
    wr(8'h11, ~8'(n));
    m[1] = n;
    ce_i <= 1'b1;
    check_outs;
    rd(8'h11);
    // Startup and shutdown delays at both step sizes
    su_code <= 4'h3;
    sd_code <= 4'h2;
    for (int s = 0; s < 2; s++) begin
      wr(8'h11, {s[0], s[0], 6'h3c});
      wr(8'h10, 8'h20);
      repeat (40) @(posedge clk_i);
      for (int up = 1; up >= 0; up--) begin
        wr(8'h10, 8'h20 | 8'(up));
        n = 0;
        while (general_output_two !== up[0] && n < 200) begin
          @(posedge clk_i);
          #1;
          n++;
        end
        lvl = (up == 1 ? 3 : 2) * FINE * (s == 1 ? 2 : 1);
        chk({7'h00, n >= lvl && n <= lvl + 6}, 8'h01);
      end
    end
    // Detector changes with sync enabled and disabled
    wr(8'h10, 8'h00);
    wr(8'h12, 8'(m[2]) & 8'hbf);
    wr(8'h12, 8'h02);
    for (int p = 1; p >= 0; p--) begin
      wr(8'h12, 8'h02 | 8'(p << 6));
      for (int e = 0; e < 2; e++) begin
        @(posedge clk_i);
        det <= ~det;
        lvl = 0;
        repeat (6) begin
          @(posedge clk_i);
          #1;
          if (evt === 1'b1) lvl++;
        end
        chk(8'(lvl), 8'(p));
        chk({7'h00, use_ext}, {7'h00, 1'(p) & det});
        st = int'({6'h00, 1'(p) & det, det});
        rd(8'h18);
      end
    end
    tally_and_finish;
  end
endmodule
